/* rtc_reload_timer.sv */
/*
  Sixteen-bit reload timer with capture, up/down count, baud clock and clock output.
  Assumes software bits arrive synchronous to sys_clk and pins are asynchronous.
*/
// Summary of operation
// R1 - Two cascaded bytes form the 16-bit count.
// R2 - Counter select picks divide-by-twelve or pin edges.
// R3 - Counting only while run control is set.
// R4 - Capture, reload and baud modes from select bits.
// R5 - Direction pin sets up or down count.
// R6 - Up overflow sets flag, loads reload pair, or zero in capture mode.
// R7 - Down match of reload loads all ones.
// R8 - External flag toggles per wrap, no interrupt.
// R9 - Clock-out counts at half oscillator, even duty.
// R10 - Clock-out reloads on wrap, raises no interrupt.
// R11 - Output clock is oscillator over four times span.
// R12 - Output clock drives shared count pin.
// R13 - Software configures before setting run control.
// R14 - Baud and clock output share reload pair.
// R15 - Without up/down, reload mode counts up only.
// R16 - Direction-pin fall captures or forces reload.
// R17 - Overflow flag only without serial clock; sticky.
// R18 - Serial clock bits route wraps, force reload.
// R19 - Output enable turns pin into clock output.
module rtc_reload_timer
  import rtc_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       srst,
  input  wire logic       runControl,
  input  wire logic       counterSelect,
  input  wire logic       serialReceiveClockSelect,
  input  wire logic       serialTransmitClockSelect,
  input  wire logic       captureReloadSelect,
  input  wire logic       externalEnable,
  input  wire logic       upDownEnable,
  input  wire logic       clockOutputEnable,
  input  wire logic       countLowWrite,
  input  wire logic       countHighWrite,
  input  wire logic       reloadLowWrite,
  input  wire logic       reloadHighWrite,
  input  wire logic [7:0] writeData,
  input  wire logic       overflowFlagClear,
  input  wire logic       externalFlagClear,
  input  wire logic       directionCapturePin,
  input  wire logic       countClockPinIn,
  output logic            countClockPinOut,
  output logic            countClockPinOe,
  output logic [7:0]      countLowByte,
  output logic [7:0]      countHighByte,
  output logic [7:0]      reloadLowByte,
  output logic [7:0]      reloadHighByte,
  output logic            overflowFlag,
  output logic            externalFlag,
  output logic            timerInterrupt,
  output logic            serialReceiveTick,
  output logic            serialTransmitTick
);

  typedef struct packed {
    logic [15:0] count;
    logic [15:0] reload;
    logic        ovf;
    logic        ext;
    logic        clkOut;
    logic        rxTick;
    logic        txTick;
  } rtc_state_t;

  rtc_state_t s_q;
  rtc_state_t s_d;
  rtc_mode_t  mode;
  logic       baudActive;
  logic       upDownActive;
  logic       countUp;
  logic       step;
  logic       wrap;
  logic       extEvent;
  logic       ovfSet;
  logic       extSet;
  logic       extToggle;

  rtc_tick_if ticks ();

  rtc_tick_gen u_tick (
    .sys_clk      (sys_clk),
    .srst         (srst),
    .countPinIn   (countClockPinIn),
    .directionPin (directionCapturePin),
    .ticks        (ticks)
  );

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  assign baudActive   = serialReceiveClockSelect | serialTransmitClockSelect;
  assign mode         = baudActive ? MODE_BAUD : (captureReloadSelect ? MODE_CAPTURE : MODE_RELOAD);  // R4 R18
  // Up/down applies to plain reload mode; clock-out and baud always count up.
  assign upDownActive = (mode == MODE_RELOAD) & upDownEnable & ~clockOutputEnable;  // R5
  assign countUp      = ~upDownActive | ticks.directionLevel;  // R5 R15

  // Clock-out overrides the counter select, which software must leave clear anyway.
  always_comb begin
    if (clockOutputEnable) begin
      step = runControl & ticks.tickClkOut;  // R9 R3
    end else if (counterSelect) begin
      step = runControl & ticks.countPinFall;  // R2 R3
    end else begin
      step = runControl & ticks.tickTimer;  // R2 R3
    end
  end

  assign wrap     = step & (countUp ? (s_q.count == COUNT_TOP) : (s_q.count == s_q.reload));  // R6 R7
  // The pin event is ignored while serving the serial port or acting as direction input.
  assign extEvent = externalEnable & ticks.directionFall & ~baudActive & ~upDownActive;  // R16

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d        = s_q;
    ovfSet     = wrap & ~baudActive & ~clockOutputEnable;  // R17 R10
    extSet     = extEvent;  // R16
    extToggle  = wrap & upDownActive;  // R8
    s_d.rxTick = wrap & serialReceiveClockSelect;  // R18
    s_d.txTick = wrap & serialTransmitClockSelect;  // R18 R14

    if (step) begin
      if (wrap) begin
        if (!countUp) begin
          s_d.count = COUNT_TOP;  // R7
        end else if (mode == MODE_CAPTURE && !clockOutputEnable) begin
          s_d.count = COUNT_RESET;
        end else begin
          s_d.count = s_q.reload;  // R6 R10 R15 R14
        end
      end else if (countUp) begin
        s_d.count = s_q.count + COUNT_ONE;  // R1
      end else begin
        s_d.count = s_q.count - COUNT_ONE;  // R5
      end
    end

    if (extEvent) begin
      if (mode == MODE_CAPTURE) begin
        s_d.reload = s_q.count;  // R16
      end else begin
        s_d.count = s_q.reload;  // R16
      end
    end

    // Each wrap of the clock-out count is one half period of the output clock.
    if (wrap && clockOutputEnable) begin
      s_d.clkOut = ~s_q.clkOut;  // R11
    end
    if (!clockOutputEnable) begin
      s_d.clkOut = CLKOUT_RESET;
    end

    // Software writes take priority over the count in the same cycle.
    if (countLowWrite) begin
      s_d.count[LOW_LSB +: 8] = writeData;
    end
    if (countHighWrite) begin
      s_d.count[HIGH_LSB +: 8] = writeData;
    end
    if (reloadLowWrite) begin
      s_d.reload[LOW_LSB +: 8] = writeData;
    end
    if (reloadHighWrite) begin
      s_d.reload[HIGH_LSB +: 8] = writeData;
    end

    // Hardware set beats software clear in the same cycle.
    if (ovfSet) begin
      s_d.ovf = 1'b1;  // R6 R17
    end else if (overflowFlagClear) begin
      s_d.ovf = 1'b0;  // R17
    end
    if (extToggle) begin
      s_d.ext = ~s_q.ext;  // R8
    end else if (extSet) begin
      s_d.ext = 1'b1;  // R16
    end else if (externalFlagClear) begin
      s_d.ext = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_q.count  <= COUNT_RESET;
      s_q.reload <= RELOAD_RESET;
      s_q.ovf    <= FLAG_RESET;
      s_q.ext    <= FLAG_RESET;
      s_q.clkOut <= CLKOUT_RESET;
      s_q.rxTick <= 1'b0;
      s_q.txTick <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign countLowByte       = s_q.count[LOW_LSB +: 8];  // R1
  assign countHighByte      = s_q.count[HIGH_LSB +: 8];  // R1
  assign reloadLowByte      = s_q.reload[LOW_LSB +: 8];
  assign reloadHighByte     = s_q.reload[HIGH_LSB +: 8];
  assign overflowFlag       = s_q.ovf;
  assign externalFlag       = s_q.ext;
  // The external flag raises no request while it serves as the seventeenth count bit.
  assign timerInterrupt     = s_q.ovf | (s_q.ext & ~upDownEnable);  // R8 R6
  assign countClockPinOut   = s_q.clkOut;  // R12
  assign countClockPinOe    = clockOutputEnable;  // R19 R12
  assign serialReceiveTick  = s_q.rxTick;
  assign serialTransmitTick = s_q.txTick;

endmodule

/* rtc_pkg.sv */
/*
  Shared constants and types of the reload timer with clock output.
  Assumes a single system clock; all users import the whole package.
*/
package rtc_pkg;

  // ----------------------------------------------------------------
  // Prescaler counts
  // ----------------------------------------------------------------
  localparam int unsigned PRE_W          = 4;
  localparam logic [PRE_W-1:0] PRE_TIMER_LAST  = 4'hB;  // Divide by twelve.
  localparam logic [PRE_W-1:0] PRE_CLKOUT_LAST = 4'h1;  // Divide by two.
  localparam logic [PRE_W-1:0] PRE_RESET       = 4'h0;

  // ----------------------------------------------------------------
  // Count values and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] COUNT_TOP    = 16'hFFFF;
  localparam logic [15:0] COUNT_ONE    = 16'h0001;
  localparam logic [15:0] COUNT_RESET  = 16'h0000;
  localparam logic [15:0] RELOAD_RESET = 16'h0000;
  localparam logic        FLAG_RESET   = 1'b0;
  localparam logic        CLKOUT_RESET = 1'b0;

  // ----------------------------------------------------------------
  // Byte lanes of the 16-bit count and reload words
  // ----------------------------------------------------------------
  localparam int unsigned LOW_LSB  = 0;
  localparam int unsigned HIGH_LSB = 8;

  typedef enum logic [1:0] {
    MODE_CAPTURE,
    MODE_RELOAD,
    MODE_BAUD
  } rtc_mode_t;

endpackage

/* rtc_tick_if.sv */
/*
  Tick and pin-event bundle between the tick generator and the timer core.
  Assumes both ends run on the same system clock.
*/
interface rtc_tick_if;
  logic tickTimer;
  logic tickClkOut;
  logic countPinFall;
  logic directionLevel;
  logic directionFall;

  modport gen (output tickTimer, output tickClkOut, output countPinFall,
               output directionLevel, output directionFall);
  modport use_ (input tickTimer, input tickClkOut, input countPinFall,
                input directionLevel, input directionFall);
endinterface

/* rtc_tick_gen.sv */
/*
  Prescalers and pin conditioning for the reload timer.
  Assumes both pins are asynchronous to sys_clk and change slower than it.
*/
module rtc_tick_gen
  import rtc_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic srst,
  input  wire logic countPinIn,
  input  wire logic directionPin,
  rtc_tick_if.gen   ticks
);

  typedef struct packed {
    logic [PRE_W-1:0] preTimer;
    logic [PRE_W-1:0] preClkOut;
    logic             pinMeta;
    logic             pinSync;
    logic             pinLast;
    logic             dirMeta;
    logic             dirSync;
    logic             dirLast;
  } rtc_tick_state_t;

  rtc_tick_state_t s_q;
  rtc_tick_state_t s_d;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d           = s_q;
    s_d.preTimer  = (s_q.preTimer == PRE_TIMER_LAST) ? PRE_RESET : s_q.preTimer + 4'h1;  // R2
    s_d.preClkOut = (s_q.preClkOut == PRE_CLKOUT_LAST) ? PRE_RESET : s_q.preClkOut + 4'h1;  // R9
    s_d.pinMeta   = countPinIn;
    s_d.pinSync   = s_q.pinMeta;
    s_d.pinLast   = s_q.pinSync;
    s_d.dirMeta   = directionPin;
    s_d.dirSync   = s_q.dirMeta;
    s_d.dirLast   = s_q.dirSync;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Edges are taken between the second and third stage, so the metastable stage feeds nothing else.
  assign ticks.tickTimer      = (s_q.preTimer == PRE_TIMER_LAST);  // R2
  assign ticks.tickClkOut     = (s_q.preClkOut == PRE_CLKOUT_LAST);  // R9
  assign ticks.countPinFall   = s_q.pinLast & ~s_q.pinSync;  // R2
  assign ticks.directionLevel = s_q.dirSync;  // R5
  assign ticks.directionFall  = s_q.dirLast & ~s_q.dirSync;  // R16

endmodule

/* rtc_reload_timer_asserts.sv */
/*
  Concurrent checks on the ports of the reload timer.
  Assumes it is bound into rtc_reload_timer and sees only that module's ports.
*/
module rtc_reload_timer_asserts (
  input wire logic       sys_clk,
  input wire logic       srst,
  input wire logic       runControl,
  input wire logic       serialReceiveClockSelect,
  input wire logic       serialTransmitClockSelect,
  input wire logic       externalEnable,
  input wire logic       upDownEnable,
  input wire logic       clockOutputEnable,
  input wire logic       countLowWrite,
  input wire logic [7:0] writeData,
  input wire logic       overflowFlagClear,
  input wire logic       countClockPinOut,
  input wire logic       countClockPinOe,
  input wire logic [7:0] countLowByte,
  input wire logic       overflowFlag,
  input wire logic       externalFlag,
  input wire logic       timerInterrupt,
  input wire logic       serialTransmitTick
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);

  a_oe_follows: assert property (countClockPinOe == clockOutputEnable)
    else $error("pin enable differs from its control");
  a_write_low: assert property (countLowWrite |=> countLowByte == $past(writeData))
    else $error("low count byte missed its write");
  // Pin-forced reloads can also move the count, so external events are excluded here.
  a_hold_stopped: assert property (!runControl && !countLowWrite && !externalEnable |=> $stable(countLowByte))
    else $error("count moved while stopped");
  a_flag_sticky: assert property (overflowFlag && !overflowFlagClear |=> overflowFlag)
    else $error("overflow flag dropped without a clear");
  a_serial_noflag: assert property ((serialReceiveClockSelect || serialTransmitClockSelect) && !overflowFlag
    |=> !overflowFlag)
    else $error("overflow flag set while clocking the serial port");
  a_clkout_noflag: assert property (clockOutputEnable && !overflowFlag |=> !overflowFlag)
    else $error("overflow flag set in clock output mode");
  a_irq_level: assert property (timerInterrupt == (overflowFlag | (externalFlag & ~upDownEnable)))
    else $error("interrupt level wrong");
  a_clkout_idle: assert property (!clockOutputEnable |=> !countClockPinOut)
    else $error("clock output active while disabled");
  a_tick_pulse: assert property ($rose(serialTransmitTick) |=> !serialTransmitTick)
    else $error("serial tick longer than one cycle");
endmodule

bind rtc_reload_timer rtc_reload_timer_asserts u_chk (.*);

/* tb_rtc_reload_timer.sv */
/*
  Self-checking bench for the reload timer; it drives every port itself.
  Assumes the checker is bound in from its own file.
*/
module tb_rtc_reload_timer;
  timeunit 1ns;
  timeprecision 1ps;
  import rtc_pkg::*;

  logic        sys_clk, srst, directionCapturePin, countClockPinIn;
  logic        countClockPinOut, countClockPinOe, overflowFlag, externalFlag;
  logic        timerInterrupt, serialReceiveTick, serialTransmitTick;
  logic [7:0]  ctl, writeData, countLowByte, countHighByte, reloadLowByte, reloadHighByte;
  logic [5:0]  strb;
  int          failCount, nChecks;
  wire  [15:0] cnt = {countHighByte, countLowByte};
  wire  [15:0] rld = {reloadHighByte, reloadLowByte};

  // Control bits, low to high: run, counter, rx, tx, capture, external, up/down, clock out.
  rtc_reload_timer DUT (
    .runControl(ctl[0]), .counterSelect(ctl[1]), .serialReceiveClockSelect(ctl[2]),
    .serialTransmitClockSelect(ctl[3]), .captureReloadSelect(ctl[4]), .externalEnable(ctl[5]),
    .upDownEnable(ctl[6]), .clockOutputEnable(ctl[7]), .countLowWrite(strb[0]), .countHighWrite(strb[1]),
    .reloadLowWrite(strb[2]), .reloadHighWrite(strb[3]), .overflowFlagClear(strb[4]),
    .externalFlagClear(strb[5]), .countClockPinIn(countClockPinIn), .*);

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    nChecks++;
    if (got !== exp) begin
      failCount++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", nChecks, failCount);
    if (failCount == 0 && nChecks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Sampling 1 ns after the edge lets that edge's register updates land first.
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input int s, input logic [7:0] d);
    @(posedge sys_clk);
    strb <= 6'h01 << s;
    writeData <= d;
    @(posedge sys_clk);
    strb <= '0;
    #1;
  endtask
  task automatic cfg(input logic [7:0] c);
    @(posedge sys_clk);
    ctl <= c;
    step(1);
  endtask
  task automatic set16(input logic [15:0] c, input logic [15:0] r);
    wr(0, c[7:0]);
    wr(1, c[15:8]);
    wr(2, r[7:0]);
    wr(3, r[15:8]);
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: return overflowFlag;
      1: return externalFlag;
      2: return countClockPinOut;
      default: return serialReceiveTick;
    endcase
  endfunction
  task automatic waitfor(input int s, input int n);
    repeat (n) begin
      step(1);
      if (sig(s) === 1'b1) return;
    end
    $display("ERROR %0t: wait ran out", $time);
    failCount++;
    tally_and_finish();
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset;
    chk(cnt, COUNT_RESET);
    chk(rld, RELOAD_RESET);
    chk({overflowFlag, externalFlag, countClockPinOut}, 16'h0000);
  endtask
  task automatic test_up;
    logic [15:0] c;
    set16(COUNT_TOP, 16'hFFFE);
    cfg(8'h01);
    waitfor(0, 30);
    chk(cnt, 16'hFFFE);
    chk(timerInterrupt, 1'b1);
    step(11);
    chk(cnt, 16'hFFFE);
    step(1);
    chk(cnt, COUNT_TOP);
    wr(4, 8'h00);
    chk(overflowFlag, 1'b0);
    cfg(8'h00);
    c = cnt;
    step(30);
    chk(cnt, c);
  endtask
  task automatic test_updown;
    cfg(8'h40);
    set16(16'h1236, 16'h1234);
    cfg(8'h41);
    waitfor(0, 100);
    chk(cnt, COUNT_TOP);
    chk(externalFlag, 1'b1);
    wr(4, 8'h00);
    chk(timerInterrupt, 1'b0);
    @(posedge sys_clk);
    directionCapturePin <= 1'b1;
    waitfor(0, 100);
    chk(cnt, 16'h1234);
    chk(externalFlag, 1'b0);
  endtask
  task automatic test_clkout;
    int n;
    wr(4, 8'h00);
    cfg(8'h80);
    wr(2, 8'hFC);
    wr(3, 8'hFF);
    wr(0, 8'hFE);
    wr(1, 8'hFF);
    cfg(8'h81);
    waitfor(2, 100);
    for (n = 1; n < 40; n++) begin
      step(1);
      if (countClockPinOut === 1'b0) break;
    end
    chk(n[15:0], 16'd8);
    chk(countClockPinOe, 1'b1);
    chk(overflowFlag, 1'b0);
    chk(timerInterrupt, 1'b0);
    cfg(8'h00);
  endtask
  task automatic test_serial;
    logic c;
    set16(COUNT_TOP, COUNT_TOP);
    cfg(8'h0D);
    waitfor(3, 40);
    chk(serialTransmitTick, 1'b1);
    chk(serialReceiveTick, 1'b1);
    chk(overflowFlag, 1'b0);
    // Baud ticks and clock output together, both paced by the one reload pair.
    cfg(8'h8D);
    waitfor(3, 20);
    c = countClockPinOut;
    step(2);
    chk(countClockPinOut, !c);
    chk(serialTransmitTick, 1'b1);
    chk(overflowFlag, 1'b0);
    cfg(8'h00);
  endtask
  task automatic test_capture;
    cfg(8'h30);
    set16(16'h5A5A, 16'h0000);
    @(posedge sys_clk);
    directionCapturePin <= 1'b0;
    waitfor(1, 20);
    chk(rld, 16'h5A5A);
    chk(timerInterrupt, 1'b1);
    wr(5, 8'h00);
    chk(externalFlag, 1'b0);
    cfg(8'h20);
    wr(0, 8'h00);
    wr(1, 8'h00);
    @(posedge sys_clk);
    directionCapturePin <= 1'b1;
    repeat (4) @(posedge sys_clk);
    directionCapturePin <= 1'b0;
    waitfor(1, 20);
    chk(cnt, 16'h5A5A);
  endtask
  task automatic test_counter;
    cfg(8'h02);
    wr(0, 8'h00);
    wr(1, 8'h00);
    cfg(8'h03);
    repeat (3) begin
      @(posedge sys_clk);
      countClockPinIn <= 1'b1;
      repeat (4) @(posedge sys_clk);
      countClockPinIn <= 1'b0;
      repeat (3) @(posedge sys_clk);
    end
    step(1);
    chk(cnt, 16'h0003);
  endtask

  initial begin
    srst = 1'b1;
    ctl = '0;
    strb = '0;
    writeData = '0;
    directionCapturePin = 1'b0;
    countClockPinIn = 1'b0;
    failCount = 0;
    nChecks = 0;
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    step(1);
    test_reset();
    test_up();
    test_updown();
    test_clkout();
    test_serial();
    test_capture();
    test_counter();
    tally_and_finish();
  end
endmodule
